/* rtl/alarm_regs.svh */
// register offsets, reset values and field positions of the alarm block
`ifndef ALARM_REGS_SVH
`define ALARM_REGS_SVH
`define ADDR_SUMMARY      10'h2C0
`define ADDR_STATUS       10'h2C1
`define ADDR_MASK         10'h2C2
`define ADDR_LANE         10'h2C4
`define ADDR_CTRL         10'h2C6
`define RST_STATUS        6'h3F
`define RST_MASK          6'h3F
`define RST_LANE          16'hFFFF
`define BIT_FIFO          5
`define BIT_PLL           4
`define BIT_LINK          3
`define BIT_REALIGN       2
`define BIT_OSC           1
`define BIT_DIV           0
`define CTRL_LINK_EN      0
`define CTRL_PIN_SEL      1
`define CTRL_MODE_66      2
`define CTRL_SOFT_RST     7
`endif

/* rtl/alarm_pkg.sv */
// types shared by the alarm status aggregator
package alarm_pkg;
  // raw alarm conditions from the converter core, pin domain
  typedef struct packed {
    logic [15:0] lane_fifo_err;
    logic        pll_locked;
    logic        link_in_data;
    logic        link_realign;
    logic        sysref_realign;
    logic        nco_sync;
    logic        nco_mismatch;
    logic        div_mismatch;
  } alarm_in_s;
  // register port request
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;
endpackage : alarm_pkg

/* rtl/alarm_status_aggregator.sv */
// alarm status aggregator: sticky flags, mask, summary and interrupt pin
//
// Implementation choice: strobed register access.
`include "alarm_regs.svh"
module alarm_status_aggregator #(
  parameter int LANES = 16
) (
  input  wire logic                 i_clock,
  input  wire logic                 i_rstn,
  input  wire alarm_pkg::alarm_in_s i_alarm,
  input  wire alarm_pkg::reg_req_s  i_req,
  output logic [7:0]                o_rdata,
  output logic                      o_irq,
  output logic                      o_cal_status_pin
);

  alarm_pkg::alarm_in_s sync1;
  alarm_pkg::alarm_in_s sync2;
  logic [5:0]       event_status_flags;
  logic [5:0]       flag_mask_bits;
  logic [15:0]      per_lane_fifo_flags;
  logic [7:0]       ctrl;
  logic             link_enable;
  logic             prev_link_enable;
  logic             soft_rst;
  logic [5:0]       set_vec;
  logic [5:0]       clr_vec;
  logic [15:0]      lane_clr;
  logic             summary;
  logic             wr_status;
  logic             wr_lane;

  // true when a write strobe targets the given register offset
  function automatic logic write_hit(input alarm_pkg::reg_req_s req,
                                     input logic [9:0]          addr);
    return req.wr && (req.addr == addr);
  endfunction : write_hit

  // assertions share the core clock and drop out during reset
  default clocking assert_clock @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= i_alarm;
      sync2 <= sync1;
    end
  end

  assign link_enable = ctrl[`CTRL_LINK_EN];
  assign soft_rst    = write_hit(i_req, `ADDR_CTRL)
                       && i_req.wdata[`CTRL_SOFT_RST];

  // link enable history for startup detection
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_link_enable <= 1'b0;
    end else begin
      prev_link_enable <= link_enable;
    end
  end

  // set conditions per flag
  always_comb begin
    set_vec = '0;
    set_vec[`BIT_FIFO] = |(sync2.lane_fifo_err[LANES-1:0]);
    set_vec[`BIT_PLL] = !sync2.pll_locked;
    if (ctrl[`CTRL_MODE_66]) begin
      set_vec[`BIT_LINK] = (link_enable && !prev_link_enable)
                           || sync2.link_realign;
    end else begin
      // enabled but not in data state
      set_vec[`BIT_LINK] = link_enable && !sync2.link_in_data;
    end
    set_vec[`BIT_REALIGN] = sync2.sysref_realign;
    set_vec[`BIT_OSC] = !link_enable || sync2.nco_sync
                        || sync2.nco_mismatch;
    set_vec[`BIT_DIV] = sync2.div_mismatch;
  end

  assign wr_status = write_hit(i_req, `ADDR_STATUS);
  assign wr_lane   = write_hit(i_req, `ADDR_LANE);
  assign clr_vec   = wr_status ? i_req.wdata[5:0] : 6'h00;
  assign lane_clr  = wr_lane ? {8'h00, i_req.wdata} : 16'h0000;

  // sticky status flags, write one to clear
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      event_status_flags <= `RST_STATUS;
    end else if (soft_rst) begin
      event_status_flags <= `RST_STATUS;
    end else begin
      event_status_flags <= (event_status_flags & ~clr_vec) | set_vec;
    end
  end

  // per-lane fifo flags, low byte writable over 8-bit port
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      per_lane_fifo_flags <= `RST_LANE;
    end else if (soft_rst) begin
      per_lane_fifo_flags <= `RST_LANE;
    end else begin
      per_lane_fifo_flags <= (per_lane_fifo_flags & ~lane_clr)
                             | sync2.lane_fifo_err;
    end
  end

  // mask and control registers
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      flag_mask_bits <= `RST_MASK;
      ctrl           <= 8'h00;
    end else begin
      if (write_hit(i_req, `ADDR_MASK)) begin
        flag_mask_bits <= i_req.wdata[5:0];
      end
      if (write_hit(i_req, `ADDR_CTRL)) begin
        ctrl <= {1'b0, i_req.wdata[6:0]};
      end
    end
  end

  // masked flags stay recorded but leave summary
  assign summary = |(event_status_flags & ~flag_mask_bits);

  // outputs from flops
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq            <= 1'b0;
      o_cal_status_pin <= 1'b0;
    end else begin
      o_irq            <= summary;
      // summary routed to status pin when selected
      o_cal_status_pin <= summary && ctrl[`CTRL_PIN_SEL];
    end
  end

  // read data one cycle after strobe
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
    end else if (i_req.rd) begin
      case (i_req.addr)
        `ADDR_SUMMARY: o_rdata <= {7'h00, summary};
        `ADDR_STATUS:  o_rdata <= {2'h0, event_status_flags};
        `ADDR_MASK:    o_rdata <= {2'h0, flag_mask_bits};
        `ADDR_LANE:    o_rdata <= per_lane_fifo_flags[7:0];
        `ADDR_CTRL:    o_rdata <= ctrl;
        default:       o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // a raw cause held for two samples is a flag two edges later,
  // since it crosses two synchroniser flops and the flag flop
  sequence pll_lost_s;
    !i_alarm.pll_locked ##1 !i_alarm.pll_locked;
  endsequence
  sequence fifo_err_s;
    (|i_alarm.lane_fifo_err) ##1 (|i_alarm.lane_fifo_err);
  endsequence
  sequence div_err_s;
    i_alarm.div_mismatch ##1 i_alarm.div_mismatch;
  endsequence
  sequence sysref_s;
    i_alarm.sysref_realign ##1 i_alarm.sysref_realign;
  endsequence
  sequence nco_upset_s;
    (i_alarm.nco_sync || i_alarm.nco_mismatch)
      ##1 (i_alarm.nco_sync || i_alarm.nco_mismatch);
  endsequence
  // startup of the link in 64b66b mode
  sequence link_start_s;
    ctrl[`CTRL_MODE_66] && link_enable && !prev_link_enable;
  endsequence

  pll_flag_a: assert property (
    pll_lost_s |-> ##2 event_status_flags[`BIT_PLL])
    else $error("pll flag not set");

  fifo_flag_a: assert property (
    fifo_err_s |-> ##2 event_status_flags[`BIT_FIFO])
    else $error("fifo flag not set");

  div_flag_a: assert property (
    div_err_s |-> ##2 event_status_flags[`BIT_DIV])
    else $error("divider flag not set");

  realign_flag_a: assert property (
    sysref_s |-> ##2 event_status_flags[`BIT_REALIGN])
    else $error("realignment flag not set");

  osc_upset_a: assert property (
    nco_upset_s |-> ##2 event_status_flags[`BIT_OSC])
    else $error("oscillator upset not flagged");

  sticky_flags_a: assert property (
    !wr_status && !soft_rst |=>
      (event_status_flags & $past(event_status_flags))
        == $past(event_status_flags))
    else $error("flag dropped without clear");

  div_clear_a: assert property (
    wr_status && clr_vec[`BIT_DIV] && !set_vec[`BIT_DIV]
      |=> !event_status_flags[`BIT_DIV])
    else $error("divider flag not cleared");

  set_wins_a: assert property (
    wr_status && set_vec[`BIT_DIV] |=> event_status_flags[`BIT_DIV])
    else $error("set lost to clear");

  summary_pin_a: assert property (
    o_cal_status_pin |-> o_irq)
    else $error("pin high without summary");

  pin_follow_a: assert property (
    summary && ctrl[`CTRL_PIN_SEL] |=> o_cal_status_pin)
    else $error("pin not driven by summary");

  irq_tie_a: assert property (
    1'b1 |=> o_irq == $past(summary))
    else $error("irq not following summary");

  summary_read_a: assert property (
    i_req.rd && (i_req.addr == `ADDR_SUMMARY) |=> o_rdata[7:1] == 7'h00)
    else $error("summary upper bits not zero");

  mask_gate_a: assert property (
    flag_mask_bits == 6'h3F |=> !o_irq)
    else $error("masked flag reached summary");

  mask_keep_a: assert property (
    set_vec[`BIT_REALIGN] && flag_mask_bits[`BIT_REALIGN]
      |=> event_status_flags[`BIT_REALIGN])
    else $error("masked flag not recorded");

  soft_reset_a: assert property (
    soft_rst |=> event_status_flags == 6'h3F)
    else $error("soft reset did not set flags");

  lane_flag_a: assert property (
    sync2.lane_fifo_err[0] |=> per_lane_fifo_flags[0])
    else $error("lane flag not set");

  lane_clear_a: assert property (
    wr_lane && i_req.wdata[0] && !sync2.lane_fifo_err[0]
      |=> !per_lane_fifo_flags[0])
    else $error("lane flag not cleared");

  osc_flag_a: assert property (
    !link_enable |=> event_status_flags[`BIT_OSC])
    else $error("oscillator flag not set");

  link_start_a: assert property (
    link_start_s |=> event_status_flags[`BIT_LINK])
    else $error("link startup not flagged");

  link_8b_a: assert property (
    !ctrl[`CTRL_MODE_66] && link_enable && !sync2.link_in_data
      |=> event_status_flags[`BIT_LINK])
    else $error("idle link not flagged");

endmodule : alarm_status_aggregator

/* dv/testbench.sv */
// self-checking bench for the alarm status aggregator
`include "alarm_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk;
  logic                 rstn;
  alarm_pkg::alarm_in_s alm;
  alarm_pkg::reg_req_s  req;
  logic [7:0]           rdata;
  logic                 irq;
  logic                 pin;
  logic [7:0]           v;
  int                   failures;
  int                   tests_run;
  // device under test
  alarm_status_aggregator alarm_status_aggregator_i (
    .i_clock(clk), .i_rstn(rstn), .i_alarm(alm), .i_req(req),
    .o_rdata(rdata), .o_irq(irq), .o_cal_status_pin(pin));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask : chk
  // one-cycle register write
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr
  // read, data sampled in the following cycle
  task automatic rchk(input logic [9:0] a, input logic [7:0] exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    @(posedge clk);
    v = rdata;
    chk(v, exp);
  endtask : rchk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // raise or drop the cause of one status flag
  task automatic cause(input int b, input logic x);
    case (b)
      5: alm.lane_fifo_err[0] <= x;
      4: alm.pll_locked <= ~x;
      3: alm.link_in_data <= ~x;
      2: alm.sysref_realign <= x;
      1: alm.nco_sync <= x;
      default: alm.div_mismatch <= x;
    endcase
  endtask : cause
  task automatic t_reset;
    rchk(`ADDR_STATUS, 8'h3F);
    rchk(`ADDR_MASK, 8'h3F);
    rchk(`ADDR_SUMMARY, 8'h00);
    rchk(10'h2C3, 8'h00);
    wr(`ADDR_CTRL, 8'h01);
    cyc(6);
    wr(`ADDR_STATUS, 8'h3F);
    wr(`ADDR_LANE, 8'hFF);
    rchk(`ADDR_STATUS, 8'h00);
    rchk(`ADDR_LANE, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_events;
    for (int b = 5; b >= 0; b--) begin
      cause(b, 1'b1);
      cyc(5);
      cause(b, 1'b0);
      cyc(5);
      rchk(`ADDR_STATUS, 8'h01 << b);
      if (b == 5) rchk(`ADDR_LANE, 8'h01);
      wr(`ADDR_STATUS, 8'h00);
      rchk(`ADDR_STATUS, 8'h01 << b);
      wr(`ADDR_STATUS, 8'h01 << b);
      if (b == 5) wr(`ADDR_LANE, 8'h01);
      rchk(`ADDR_STATUS, 8'h00);
    end
    $display("test events done");
  endtask : t_events
  task automatic t_mask;
    wr(`ADDR_MASK, 8'h3B);
    cause(2, 1'b1);
    cyc(5);
    cause(2, 1'b0);
    cyc(3);
    chk({7'h00, irq}, 8'h01);
    rchk(`ADDR_SUMMARY, 8'h01);
    chk({7'h00, pin}, 8'h00);
    wr(`ADDR_CTRL, 8'h03);
    cyc(2);
    chk({7'h00, pin}, 8'h01);
    wr(`ADDR_MASK, 8'h3F);
    cyc(3);
    chk({7'h00, irq}, 8'h00);
    rchk(`ADDR_STATUS, 8'h04);
    wr(`ADDR_STATUS, 8'h04);
    $display("test mask done");
  endtask : t_mask
  task automatic t_misc;
    cause(0, 1'b1);
    cyc(5);
    wr(`ADDR_STATUS, 8'h01);
    rchk(`ADDR_STATUS, 8'h01);
    cause(0, 1'b0);
    cyc(5);
    wr(`ADDR_STATUS, 8'h01);
    wr(`ADDR_CTRL, 8'h04);
    wr(`ADDR_CTRL, 8'h05);
    cyc(5);
    rchk(`ADDR_STATUS, 8'h0A);
    wr(`ADDR_CTRL, 8'h81);
    cyc(2);
    rchk(`ADDR_STATUS, 8'h3F);
    $display("test misc done");
  endtask : t_misc
  task automatic print_verdict;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // main sequence
  initial begin
    rstn = 1'b0;
    alm = '{pll_locked: 1'b1, link_in_data: 1'b1, default: '0};
    req = '0;
    failures = 0;
    tests_run = 0;
    cyc(10);
    rstn <= 1'b1;
    t_reset;
    t_events;
    t_mask;
    t_misc;
    print_verdict;
  end
  // hang guard
  initial begin
    cyc(20000);
    failures++;
    print_verdict;
  end
endmodule : testbench
